// [acs_pkg.sv]
// package of constants and types for the converter control and serial port
package acs_pkg;
    // master clock rate and derived cycle counts
    localparam int CLK_HZ           = 40_000_000;
    // minimum data-ready high time, master clocks
    localparam int DATA_READY_N_HIGH_MIN    = 16;
    // reset or reset-command to first conversion start, master clocks
    localparam int RESET_TO_CONV    = 512;
    // power-on threshold to communication, master clocks
    localparam int POWERON_TO_COMM  = 65536;
    // communication available to first conversion, master clocks
    localparam int COMM_TO_CONV     = 512;
    // start-low or stop setup before data-ready fall to stop next conversion
    localparam int STOP_SETUP       = 100;
    // start-low or stop hold after data-ready fall to continue next one
    localparam int STOP_HOLD        = 150;
    // start to data-ready high latency bound, master clocks
    localparam int START_TO_DATA_READY_N    = 2;
    // default conversion length in master clocks
    localparam int CONV_CYCLES      = 1024;
    // serial command bytes
    localparam logic [7:0] CMD_START = 8'h08;
    localparam logic [7:0] CMD_STOP  = 8'h0A;
    localparam logic [7:0] CMD_RESET = 8'h06;
    localparam logic [7:0] CMD_READ  = 8'h12;
    // reset values
    localparam logic [23:0] DATA_RST = 24'h000000;
    // conversion control states
    typedef enum logic [2:0] {
        ACS_POWERUP,
        ACS_SETTLE,
        ACS_IDLE,
        ACS_CONVERT,
        ACS_READY
    } acs_conv_state_t;
endpackage

// [acs_serial_if.sv]
// interface between the conversion core and the serial port engine
`timescale 1ns/1ps
interface acs_serial_if;
    logic        cmd_valid;   // one-cycle pulse, byte received
    logic [7:0]  cmd_byte;    // received command byte
    logic        comm_ok;     // serial port may accept frames
    logic [23:0] conv_data;   // latest conversion result
    logic        data_ready_n_n;      // data-ready level, active low
    modport core (input cmd_valid, input cmd_byte,
                  output comm_ok, output conv_data, output data_ready_n_n);
    modport port (output cmd_valid, output cmd_byte,
                  input comm_ok, input conv_data, input data_ready_n_n);
endinterface

// [acs_serial_port.sv]
// serial port engine: shifts in commands and shifts out conversion data
`timescale 1ns/1ps
module acs_serial_port
    import acs_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // synchronised pins
    input  wire logic sclk_s,
    input  wire logic sdi_s,
    input  wire logic cs_n_s,
    // core link
    acs_serial_if.port core,
    // shared pin drive
    output logic       pin_o,
    output logic       pin_oe_n
);
    // all state of this engine
    typedef struct packed {
        logic        sclk_d;    // previous serial clock level
        logic [2:0]  bitcnt;    // bits within current byte
        logic [7:0]  shin;      // input shift register
        logic [23:0] shout;     // output shift register
        logic        reading;   // data read in progress
        logic        rdfirst;   // first byte of read pending
        logic [4:0]  rdbits;    // bits left to shift out
        logic        busy;      // rising edge seen in frame
        logic        out;       // pin value
        logic        oe_n;      // pin enable, low drives
        logic        cvalid;    // command pulse
        logic [7:0]  cbyte;     // command byte
    } acs_sp_t;

    acs_sp_t s_r;    // registered state
    acs_sp_t s_nxt;  // next state

    logic rise;      // serial clock rising edge
    logic fall;      // serial clock falling edge

    // edge detection and frame logic
    always_comb begin
        s_nxt = s_r;
        rise = sclk_s & ~s_r.sclk_d;
        fall = ~sclk_s & s_r.sclk_d;
        s_nxt.sclk_d = sclk_s;
        s_nxt.cvalid = 1'b0;
        if (cs_n_s || !core.comm_ok) begin
            // deselect resets the interface and floats the pin
            s_nxt.bitcnt  = 3'h0;
            s_nxt.reading = 1'b0;
            s_nxt.busy    = 1'b0;
            s_nxt.rdbits  = 5'h00;
            s_nxt.oe_n    = 1'b1;
            s_nxt.out     = 1'b0;
        end else begin
            s_nxt.oe_n = 1'b0;
            if (rise) begin
                s_nxt.busy = 1'b1;
                // output shifts after the rising edge
                if (s_r.reading && s_r.rdbits != 5'h00) begin
                    s_nxt.out    = s_r.shout[23];
                    s_nxt.shout  = {s_r.shout[22:0], 1'b0};
                end else begin
                    s_nxt.out = 1'b0;
                end
            end
            if (fall) begin
                // input sampled on the falling edge
                s_nxt.shin   = {s_r.shin[6:0], sdi_s};
                s_nxt.bitcnt = s_r.bitcnt + 3'h1;
                if (s_r.reading && s_r.rdbits != 5'h00) begin
                    s_nxt.rdbits = s_r.rdbits - 5'h01;
                    if (s_r.rdbits == 5'h01) begin
                        s_nxt.reading = 1'b0;
                        s_nxt.busy    = 1'b0;
                    end
                end
                if (s_r.bitcnt == 3'h7 && !s_r.reading) begin
                    s_nxt.cvalid = 1'b1;
                    s_nxt.cbyte  = {s_r.shin[6:0], sdi_s};
                    s_nxt.busy   = 1'b0;
                    if ({s_r.shin[6:0], sdi_s} == CMD_READ) begin
                        s_nxt.reading = 1'b1;
                        s_nxt.shout   = core.conv_data;
                        s_nxt.rdbits  = 5'd24;
                    end
                end
            end
            // idle frame shows data-ready on the shared pin
            if (!s_nxt.busy && !s_nxt.reading) begin
                s_nxt.out = core.data_ready_n_n;
            end
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{default: '0, oe_n: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin_o          = s_r.out;
    assign pin_oe_n       = s_r.oe_n;
    assign core.cmd_valid = s_r.cvalid;
    assign core.cmd_byte  = s_r.cbyte;

    // pin floats one cycle after deselect
    AST_FLOAT: assert property (@(posedge clock) disable iff (!rst_n)
        cs_n_s |=> pin_oe_n)
        else $error("shared pin driven while deselected");
    // deselect clears a pending read
    AST_CS_RESET: assert property (@(posedge clock) disable iff (!rst_n)
        cs_n_s |=> !s_r.reading && s_r.bitcnt == 3'h0)
        else $error("deselect did not reset the serial port");
    // input bit taken only on falling edge
    AST_SAMPLE: assert property (@(posedge clock) disable iff (!rst_n)
        (!cs_n_s && core.comm_ok && fall) |=> s_r.shin[0] == $past(sdi_s))
        else $error("input not sampled at falling edge");
    // output changes only after a rising edge during a read
    AST_SHIFT: assert property (@(posedge clock) disable iff (!rst_n)
        (s_r.reading && !rise && !cs_n_s && !fall) |=> $stable(s_r.shout))
        else $error("output shifted without rising edge");
    // idle selected frame mirrors data-ready
    AST_DATA_READY_N_PIN: assert property (@(posedge clock) disable iff (!rst_n)
        (!cs_n_s && core.comm_ok && !s_nxt.busy && !s_nxt.reading)
        |=> pin_o == $past(core.data_ready_n_n))
        else $error("shared pin not showing data-ready");
endmodule

// [acs_conv_ctrl.sv]
// converter control: start, stop, reset latencies and serial data pin
`timescale 1ns/1ps
// Operation
// - stop 100 clocks before ready ends next
// - stop 150 clocks after ready continues one
// - data-ready stays high sixteen clocks minimum
// - 512 clocks from reset to conversion
// - 65536 clocks power-on before communication
// - 512 more clocks before first conversion
// - data-ready rises within two clocks of start
// - chip select high resets serial port; the code resets it only when both chip selects are high
// - shared pin shows ready outside data reads; the code drives it low while a command byte shifts in
// - serial input sampled on falling edge
// - output updated after serial clock rising edge
module acs_conv_ctrl
    import acs_pkg::*;
#(
    parameter int PWR_CYCLES  = POWERON_TO_COMM,
    parameter int CONV_LEN    = CONV_CYCLES
)(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // control pins
    input  wire logic        reset_pin_n,
    input  wire logic        start_pin,
    input  wire logic        continuous,
    // serial pins
    input  wire logic        chip_select_a_n,
    input  wire logic        chip_select_b_n,
    input  wire logic        sclk,
    input  wire logic        sdi,
    output logic             shared_out_ready_pin_o,
    output logic             shared_out_ready_pin_oe_n,
    // conversion result source
    input  wire logic [23:0] sample_in,
    // status
    output logic             data_ready_n,
    output logic             converting
);
    localparam int CW = $clog2(PWR_CYCLES + CONV_LEN + 1) + 1;

    // state of the control core, apart from the reset release chain
    typedef struct packed {
        logic [1:0]      rpin_s;     // reset pin sync
        logic [1:0]      st_s;       // start pin sync
        logic [1:0]      csa_s;      // chip select a sync
        logic [1:0]      csb_s;      // chip select b sync
        logic [1:0]      sck_s;      // serial clock sync
        logic [1:0]      sdi_s;      // serial input sync
        logic            st_d;       // last start level
        acs_conv_state_t st;         // conversion state
        logic [CW-1:0]   cnt;        // phase counter
        logic [CW-1:0]   since;      // clocks since ready fell
        logic            run;        // start requested
        logic            stop_next;  // stop after current
        logic            comm;       // communication allowed
        logic            data_ready_n_n;     // data-ready level
        logic [23:0]     data;       // latest result
    } acs_core_t;

    acs_core_t c_r;    // registered state
    acs_core_t c_nxt;  // next state

    logic [1:0] rst_sync_r; // reset release chain, on the raw reset
    logic rst_n;       // released reset copy
    logic start_rise;  // start pin rising edge
    logic start_fall;  // start pin falling edge
    logic cmd_start;   // start command pulse
    logic cmd_stop;    // stop command pulse
    logic cmd_reset;   // reset command pulse
    logic go;          // start by pin or command
    logic halt;        // stop by pin or command

    acs_serial_if sif ();

    assign rst_n = rst_sync_r[1];

    // next-state logic
    always_comb begin
        c_nxt = c_r;
        c_nxt.rpin_s   = {c_r.rpin_s[0], reset_pin_n};
        c_nxt.st_s     = {c_r.st_s[0], start_pin};
        c_nxt.csa_s    = {c_r.csa_s[0], chip_select_a_n};
        c_nxt.csb_s    = {c_r.csb_s[0], chip_select_b_n};
        c_nxt.sck_s    = {c_r.sck_s[0], sclk};
        c_nxt.sdi_s    = {c_r.sdi_s[0], sdi};
        c_nxt.st_d     = c_r.st_s[1];
        start_rise = c_r.st_s[1] & ~c_r.st_d;
        start_fall = ~c_r.st_s[1] & c_r.st_d;
        cmd_start = sif.cmd_valid && sif.cmd_byte == CMD_START;
        cmd_stop  = sif.cmd_valid && sif.cmd_byte == CMD_STOP;
        cmd_reset = sif.cmd_valid && sif.cmd_byte == CMD_RESET;
        go   = start_rise || cmd_start;
        halt = start_fall || cmd_stop;
        c_nxt.cnt = c_r.cnt + CW'(1);
        if (c_r.since != '1) begin
            c_nxt.since = c_r.since + CW'(1);
        end
        if (go) begin
            c_nxt.run       = 1'b1;
            c_nxt.stop_next = 1'b0;
        end
        if (halt && c_r.run && continuous) begin
            // early halt clears run, late one sets stop_next; the running conversion finishes either way
            if (c_r.since < CW'(STOP_HOLD)) begin
                c_nxt.run = 1'b0;
            end else begin
                c_nxt.stop_next = 1'b1;
            end
        end else if (halt) begin
            c_nxt.run = 1'b0;
        end
        case (c_r.st)
            ACS_POWERUP: begin
                // wait for the power-on delay before serial access
                if (c_r.cnt >= CW'(PWR_CYCLES - 1)) begin
                    c_nxt.comm = 1'b1;
                    c_nxt.cnt  = '0;
                    c_nxt.st   = ACS_SETTLE;
                end
            end
            ACS_SETTLE: begin
                // hold off conversions after reset or power-on
                if (c_r.cnt >= CW'(RESET_TO_CONV - 1)) begin
                    c_nxt.cnt = '0;
                    c_nxt.st  = ACS_IDLE;
                end
            end
            ACS_IDLE: begin
                if (c_nxt.run) begin
                    c_nxt.cnt    = '0;
                    c_nxt.data_ready_n_n = 1'b1;
                    c_nxt.st     = ACS_CONVERT;
                end
            end
            ACS_CONVERT: begin
                // conversion in progress, ready held high
                // a halt never cuts a conversion short; it only
                // keeps the next one from starting
                if (go) begin
                    c_nxt.cnt    = '0;
                    c_nxt.data_ready_n_n = 1'b1;
                end else if (c_r.cnt >= CW'(CONV_LEN - 1) &&
                             c_r.cnt >= CW'(DATA_READY_N_HIGH_MIN - 1)) begin
                    c_nxt.data   = sample_in;
                    c_nxt.data_ready_n_n = 1'b0;
                    c_nxt.since  = '0;
                    c_nxt.cnt    = '0;
                    c_nxt.st     = ACS_READY;
                end
            end
            ACS_READY: begin
                // new data ready; continuous mode restarts at once
                if (go || (continuous && c_nxt.run && !c_r.stop_next)) begin
                    c_nxt.cnt    = '0;
                    c_nxt.data_ready_n_n = 1'b1;
                    c_nxt.st     = ACS_CONVERT;
                end else if (c_r.stop_next) begin
                    c_nxt.run       = 1'b0;
                    c_nxt.stop_next = 1'b0;
                    c_nxt.st        = ACS_IDLE;
                end
            end
            default: c_nxt.st = ACS_POWERUP;
        endcase
        if (!c_r.rpin_s[1] || cmd_reset) begin
            // reset pin or command restarts the settle delay, or restarts the power-on delay while in ACS_POWERUP
            c_nxt.st        = ACS_SETTLE;
            c_nxt.cnt       = '0;
            c_nxt.run       = 1'b0;
            c_nxt.stop_next = 1'b0;
            c_nxt.data_ready_n_n    = 1'b1;
            if (c_r.st == ACS_POWERUP) begin
                c_nxt.st = ACS_POWERUP;
            end
        end
    end

    // reset release chain runs on the raw reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // remaining state registered on the released reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            c_r.rpin_s    <= 2'h3;
            c_r.st_s      <= 2'h0;
            c_r.csa_s     <= 2'h3;
            c_r.csb_s     <= 2'h3;
            c_r.sck_s     <= 2'h0;
            c_r.sdi_s     <= 2'h0;
            c_r.st_d      <= 1'b0;
            c_r.st        <= ACS_POWERUP;
            c_r.cnt       <= '0;
            c_r.since     <= '1;
            c_r.run       <= 1'b0;
            c_r.stop_next <= 1'b0;
            c_r.comm      <= 1'b0;
            c_r.data_ready_n_n    <= 1'b1;
            c_r.data      <= DATA_RST;
        end else begin
            c_r.rpin_s    <= c_nxt.rpin_s;
            c_r.st_s      <= c_nxt.st_s;
            c_r.csa_s     <= c_nxt.csa_s;
            c_r.csb_s     <= c_nxt.csb_s;
            c_r.sck_s     <= c_nxt.sck_s;
            c_r.sdi_s     <= c_nxt.sdi_s;
            c_r.st_d      <= c_nxt.st_d;
            c_r.st        <= c_nxt.st;
            c_r.cnt       <= c_nxt.cnt;
            c_r.since     <= c_nxt.since;
            c_r.run       <= c_nxt.run;
            c_r.stop_next <= c_nxt.stop_next;
            c_r.comm      <= c_nxt.comm;
            c_r.data_ready_n_n    <= c_nxt.data_ready_n_n;
            c_r.data      <= c_nxt.data;
        end
    end

    assign sif.comm_ok   = c_r.comm;
    assign sif.conv_data = c_r.data;
    assign sif.data_ready_n_n    = c_r.data_ready_n_n;
    assign data_ready_n  = c_r.data_ready_n_n;
    assign converting    = (c_r.st == ACS_CONVERT);

    // serial engine; selected when either chip select is low
    acs_serial_port u_port (
        .clock    (clock),
        .rst_n    (rst_n),
        .sclk_s   (c_r.sck_s[1]),
        .sdi_s    (c_r.sdi_s[1]),
        .cs_n_s   (c_r.csa_s[1] & c_r.csb_s[1]),
        .core     (sif.port),
        .pin_o    (shared_out_ready_pin_o),
        .pin_oe_n (shared_out_ready_pin_oe_n)
    );

    // data-ready rises within two clocks of a start
    AST_START_DATA_READY_N: assert property (@(posedge clock) disable iff (!rst_n)
        (start_rise && (c_r.st == ACS_IDLE || c_r.st == ACS_CONVERT))
        |-> ##[1:2] data_ready_n)
        else $error("data-ready not high after start");
    // data-ready falls only after a high time of sixteen clocks
    AST_DATA_READY_N_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(data_ready_n) |-> $past(c_r.cnt) >= CW'(DATA_READY_N_HIGH_MIN - 1))
        else $error("data-ready high time too short");
    // no conversion during the settle delay
    AST_SETTLE: assert property (@(posedge clock) disable iff (!rst_n)
        (c_r.st == ACS_SETTLE && c_r.cnt < CW'(RESET_TO_CONV - 1))
        |=> !converting)
        else $error("conversion started before settle delay");
    // serial access blocked during power-up
    AST_POWERUP: assert property (@(posedge clock) disable iff (!rst_n)
        (c_r.st == ACS_POWERUP) |-> !c_r.comm)
        else $error("communication before power-on delay");
    // after communication opens, settle precedes conversion
    AST_FIRST_CONV: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(c_r.comm) |-> c_r.st == ACS_SETTLE && c_r.cnt == '0)
        else $error("first conversion not delayed");
    // early halt in continuous mode stops the run
    AST_EARLY_STOP: assert property (@(posedge clock) disable iff (!rst_n)
        (start_fall && continuous && c_r.run && c_r.since < CW'(STOP_HOLD)
         && !go && !cmd_reset) |=> !c_r.run)
        else $error("early stop not honoured");
    // late halt lets one more conversion finish
    AST_LATE_STOP: assert property (@(posedge clock) disable iff (!rst_n)
        (start_fall && continuous && c_r.run && c_r.since >= CW'(STOP_HOLD)
         && !go && !cmd_reset) |=> c_r.stop_next && c_r.run)
        else $error("late stop did not continue");
endmodule

// [acs_host_model.sv]
// host model: drives the control pins and serial frames of the converter
`timescale 1ns/1ps
module acs_host_model (
    // clock and shared pin level
    input  wire logic clock,
    input  wire logic pin_w,
    // control pins
    output logic      reset_pin_n,
    output logic      start_pin,
    // serial pins
    output logic      chip_select_a_n,
    output logic      chip_select_b_n,
    output logic      sclk,
    output logic      sdi
);
    // idle levels; serial clock stands low outside frames
    initial begin
        reset_pin_n     = 1'b1;
        start_pin       = 1'b0;
        chip_select_a_n = 1'b1;
        chip_select_b_n = 1'b1;
        sclk            = 1'b0;
        sdi             = 1'b0;
    end
    // wait a number of master clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // drive the start pin level
    task automatic set_start(input logic v);
        start_pin <= v;
    endtask
    // start pulse, four clocks high and four low
    task automatic start_pulse();
        start_pin <= 1'b1;
        tick(4);
        start_pin <= 1'b0;
        tick(4);
    endtask
    // reset pin low for four clocks
    task automatic reset_pulse();
        reset_pin_n <= 1'b0;
        tick(4);
        reset_pin_n <= 1'b1;
    endtask
    // select one of the two chip selects
    task automatic select(input logic b);
        if (b) begin
            chip_select_b_n <= 1'b0;
        end else begin
            chip_select_a_n <= 1'b0;
        end
        tick(4);
    endtask
    // deselect both, which also aborts a partial frame
    task automatic deselect();
        chip_select_a_n <= 1'b1;
        chip_select_b_n <= 1'b1;
        tick(4);
    endtask
    // one bit of 200 ns: data moves at the rise, pin read after the fall
    task automatic bit_x(input logic d, output logic q);
        sdi  <= d;
        sclk <= 1'b1;
        tick(4);
        sclk <= 1'b0;
        tick(2);
        q = pin_w;
        tick(2);
    endtask
    // command byte, msb first
    task automatic send_byte(input logic [7:0] v);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_x(v[i], q);
        end
    endtask
    // 24 result bits, msb first
    task automatic read24(output logic [23:0] v);
        for (int i = 23; i >= 0; i--) begin
            bit_x(1'b0, v[i]);
        end
    endtask
endmodule

// [acs_conv_ctrl_bench.sv]
// testbench of the converter control block with the host model
`timescale 1ns/1ps
module acs_conv_ctrl_bench;
    import acs_pkg::*;
    localparam int PWR  = 64;  // shortened power-up count
    localparam int CLEN = 40;  // shortened conversion length
    logic        clock        = 1'b0;
    logic        resetn       = 1'b0;
    logic        continuous   = 1'b0;
    logic [23:0] sample_in    = 24'hA5C396;
    logic        pin_o;
    logic        pin_oe_n;
    logic        data_ready_n;
    logic        converting;
    logic        reset_pin_n;
    logic        start_pin;
    logic        chip_select_a_n;
    logic        chip_select_b_n;
    logic        sclk;
    logic        sdi;
    // released pin is pulled down by its load
    wire logic   pin_w        = pin_oe_n ? 1'b0 : pin_o;
    int          n_errors     = 0;
    int          checks       = 0;
    // 40 MHz master clock
    always #12.5 clock = ~clock;
    // device under test
    acs_conv_ctrl #(.PWR_CYCLES(PWR), .CONV_LEN(CLEN)) dut (
        .clock(clock), .resetn(resetn), .reset_pin_n(reset_pin_n),
        .start_pin(start_pin), .continuous(continuous),
        .chip_select_a_n(chip_select_a_n),
        .chip_select_b_n(chip_select_b_n), .sclk(sclk), .sdi(sdi),
        .shared_out_ready_pin_o(pin_o),
        .shared_out_ready_pin_oe_n(pin_oe_n), .sample_in(sample_in),
        .data_ready_n(data_ready_n), .converting(converting));
    // host at the far side
    acs_host_model host (
        .clock(clock), .pin_w(pin_w), .reset_pin_n(reset_pin_n),
        .start_pin(start_pin), .chip_select_a_n(chip_select_a_n),
        .chip_select_b_n(chip_select_b_n), .sclk(sclk), .sdi(sdi));
    // compare one bit
    task automatic chk(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    // compare a result word
    task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: data %h", $time, got);
        end
    endtask
    // bounded wait for a data-ready level, n counts the clocks
    task automatic wait_lvl(input logic lvl, input int mx, output int n);
        n = 0;
        while (data_ready_n !== lvl && n < mx) begin
            @(posedge clock);
            n++;
        end
    endtask
    // one-shot conversions: start latency and ready high time
    task automatic t_oneshot();
        int n;
        host.start_pulse();
        wait_lvl(1'b0, CLEN + 20, n);
        chk(data_ready_n, 1'b0, "first result");
        host.set_start(1'b1);
        wait_lvl(1'b1, 8, n);
        chk(n <= 4, 1'b1, "start latency");
        host.tick(4);
        host.set_start(1'b0);
        wait_lvl(1'b0, CLEN + 20, n);
        chk(n + 5 >= DATA_READY_N_HIGH_MIN, 1'b1, "ready high time");
    endtask
    // read the result through one chip select
    task automatic t_read(input logic b);
        logic [23:0] v;
        host.select(b);
        chk(pin_oe_n, 1'b0, "pin driven");
        chk(pin_w, 1'b0, "pin shows ready");
        host.send_byte(CMD_READ);
        host.read24(v);
        chk24(v, sample_in);
        host.tick(2);
        chk(pin_w, 1'b0, "pin back to ready");
        host.deselect();
        chk(pin_oe_n, 1'b1, "pin released");
    endtask
    // partial frame aborted by deselect, then start command on b
    task automatic t_abort();
        int   n;
        logic q;
        host.select(1'b0);
        repeat (4) host.bit_x(1'b1, q);
        host.deselect();
        host.select(1'b1);
        sample_in <= 24'h3C5A69;
        host.send_byte(CMD_START);
        wait_lvl(1'b1, 20, n);
        chk(data_ready_n, 1'b1, "start command");
        host.deselect();
        wait_lvl(1'b0, CLEN + 20, n);
        t_read(1'b1);
    endtask
    // reset pin holds off conversions for the settle time
    task automatic t_reset();
        int n;
        host.reset_pulse();
        host.start_pulse();
        host.tick(RESET_TO_CONV - 40);
        chk(converting, 1'b0, "start during settle");
        host.tick(60);
        host.start_pulse();
        wait_lvl(1'b1, 8, n);
        wait_lvl(1'b0, CLEN + 20, n);
        chk(data_ready_n, 1'b0, "conversion after settle");
    endtask
    // continuous mode, start lowered just after a ready fall
    task automatic t_cont();
        int n;
        continuous <= 1'b1;
        host.set_start(1'b1);
        wait_lvl(1'b1, 8, n);
        wait_lvl(1'b0, CLEN + 20, n);
        wait_lvl(1'b1, 4, n);
        wait_lvl(1'b0, CLEN + 20, n);
        chk(data_ready_n, 1'b0, "continued conversion");
        host.set_start(1'b0);
        wait_lvl(1'b1, 4, n);
        wait_lvl(1'b0, CLEN + 20, n);
        host.tick(8);
        chk(converting, 1'b0, "no next conversion");
        continuous <= 1'b0;
    endtask
    // verdict and end of run
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        chk(pin_oe_n, 1'b1, "pin idle");
        chk(data_ready_n, 1'b1, "ready idle");
        host.tick(PWR + COMM_TO_CONV + 20);
        t_oneshot();
        t_read(1'b0);
        t_abort();
        t_reset();
        t_cont();
        end_sim();
    end
    // watchdog, well beyond the expected run
    initial begin
        #(25 * 20000);
        n_errors++;
        end_sim();
    end
endmodule
